// ==== hw/gpc_prot_cfg.sv ====
// protection configuration register bank with fault turn-off policy decode
`timescale 1ns/1ps
`include "gpc_consts.svh"

module gpc_prot_cfg #(
	parameter int MUTE_CYCLES = `GPC_MUTE_CYCLES
) (
	input  wire logic                      core_clk,          // 10 MHz clock
	input  wire logic                      rst_b,             // async reset, active low
	input  wire logic                      cfg_wr_en,         // write strobe from serial port
	input  wire logic                      cfg_sel,           // 0 first word, 1 second word
	input  wire logic [`GPC_WORD_W-1:0]    cfg_wdata,         // write data
	input  wire logic                      cfg_rd_en,         // read strobe
	output logic      [`GPC_WORD_W-1:0]    cfg_rdata,         // read data, one cycle later
	input  wire gpc_pkg::gpc_fault_t       fault_in,          // asynchronous fault levels
	input  wire logic                      turnoff_busy_in,   // soft/two-level turnoff running
	input  wire logic                      pwm_in,            // incoming pwm command
	output gpc_pkg::gpc_prot_t             prot_cfg,          // first word fields
	output gpc_pkg::gpc_turnoff_t          turnoff_cfg,       // second word fields
	output logic                           soft_turnoff,      // soft turn-off request
	output logic                           two_level_turnoff, // two-level turn-off request
	output logic                           gm_detect_allow,   // gate monitor may flag faults
	output logic      [5:0]                gm_blank_cycles,   // gate monitor blanking in cycles
	output logic      [13:0]               sat_threshold_mv,  // desat threshold in mV
	output logic                           pwm_muted,         // muting in progress
	output logic                           pwm_out            // pwm after muting
);

	// ==========================================================
	// blanking lookup
	function automatic logic [5:0] blank_cycles(input logic [1:0] code);
		logic [5:0] r;
		r = 6'h0;
		case (code)
			2'h0: r = 6'((`GPC_GM_BLK0_NS) / (`GPC_CLK_NS));
			2'h1: r = 6'((`GPC_GM_BLK1_NS) / (`GPC_CLK_NS));
			2'h2: r = 6'((`GPC_GM_BLK2_NS) / (`GPC_CLK_NS));
			2'h3: r = 6'((`GPC_GM_BLK3_NS) / (`GPC_CLK_NS));
			default: r = 6'h0;
		endcase
		return r;
	endfunction

	// fault coverage of a policy code
	function automatic logic policy_hit(input logic [1:0] lvl, input gpc_pkg::gpc_fault_t f);
		logic h;
		h = 1'b0;
		if (lvl >= 2'h1) begin
			h = f.short_circuit | f.desat;
		end
		if (lvl >= 2'h2) begin
			h = h | f.overcurrent;
		end
		if (lvl == 2'h3) begin
			h = h | f.switch_thermal;
		end
		return h;
	endfunction

	// ==========================================================
	// synchronisers
	logic [5:0]          sync1_q;
	logic [5:0]          sync2_q;
	gpc_pkg::gpc_fault_t flt_s;
	logic                busy_s;
	logic                pwm_s;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 6'h0;
			sync2_q <= 6'h0;
		end else begin
			sync1_q <= {fault_in, turnoff_busy_in, pwm_in};
			sync2_q <= sync1_q;
		end
	end

	assign flt_s  = sync2_q[5:2];
	assign busy_s = sync2_q[1];
	assign pwm_s  = sync2_q[0];

	// ==========================================================
	// register bank
	logic [`GPC_PROT_W-1:0] prot_q;
	logic [`GPC_WORD_W-1:0] toff_q;

	// reset and write of first word
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prot_q <= `GPC_PROT_RST;
		end else if (cfg_wr_en && cfg_sel == `GPC_SEL_PROT) begin
			prot_q <= cfg_wdata[`GPC_PROT_W-1:0];
		end
	end

	// reset and write of second word
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			toff_q <= `GPC_TURNOFF_RST;
		end else if (cfg_wr_en && cfg_sel == `GPC_SEL_TURNOFF) begin
			toff_q <= cfg_wdata;
		end
	end

	// upper bits of first word belong elsewhere and read zero
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_rdata <= 16'h0;
		end else if (cfg_rd_en) begin
			cfg_rdata <= (cfg_sel == `GPC_SEL_PROT) ? {4'h0, prot_q} : toff_q;
		end
	end

	// fields drive the analog side through one register stage
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prot_cfg    <= gpc_pkg::gpc_prot_t'(`GPC_PROT_RST);
			turnoff_cfg <= gpc_pkg::gpc_turnoff_t'(`GPC_TURNOFF_RST);
		end else begin
			prot_cfg    <= gpc_pkg::gpc_prot_t'(prot_q);
			turnoff_cfg <= gpc_pkg::gpc_turnoff_t'(toff_q);
		end
	end

	// ==========================================================
	// derived settings
	gpc_pkg::gpc_prot_t    pc;
	gpc_pkg::gpc_turnoff_t tc;
	assign pc = gpc_pkg::gpc_prot_t'(prot_q);
	assign tc = gpc_pkg::gpc_turnoff_t'(toff_q);

	// blanking code to cycles, linear threshold
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gm_blank_cycles  <= 6'h0;
			sat_threshold_mv <= 14'h0;
		end else begin
			gm_blank_cycles  <= blank_cycles(pc.gate_monitor_blank_time);
			sat_threshold_mv <= 14'(`GPC_DTH_BASE_MV)
				+ 14'(tc.saturation_threshold_code) * 14'(`GPC_DTH_STEP_MV);
		end
	end

	// monitor off, masked while turn-off runs
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gm_detect_allow <= 1'b0;
		end else begin
			gm_detect_allow <= !pc.gate_monitor_off
				&& !(tc.gate_monitor_mask_in_turnoff && busy_s);
		end
	end

	// ==========================================================
	// fault turn-off policy
	gpc_pkg::gpc_fault_t flt_en;
	logic                pol_hit;

	assign flt_en.short_circuit  = flt_s.short_circuit && !pc.short_protect_off;
	assign flt_en.desat          = flt_s.desat && pc.saturation_detect_on;
	assign flt_en.overcurrent    = flt_s.overcurrent && !pc.overcurrent_protect_off;
	assign flt_en.switch_thermal = flt_s.switch_thermal && pc.switch_thermal_protect_on;
	assign pol_hit = policy_hit(tc.fault_turnoff_policy[1:0], flt_en);

	// bit 2 picks two-level over soft
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			soft_turnoff      <= 1'b0;
			two_level_turnoff <= 1'b0;
		end else begin
			soft_turnoff      <= pol_hit && !tc.fault_turnoff_policy[2];
			two_level_turnoff <= pol_hit && tc.fault_turnoff_policy[2];
		end
	end

	// ==========================================================
	// pwm muting
	logic        mute_flt;
	logic        mute_flt_q;
	logic [15:0] mute_cnt_q;
	assign mute_flt = flt_en.short_circuit | flt_en.overcurrent | flt_en.switch_thermal;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mute_flt_q <= 1'b0;
			mute_cnt_q <= 16'h0;
		end else begin
			mute_flt_q <= mute_flt;
			if (mute_flt && !mute_flt_q && tc.pwm_mute_on) begin
				mute_cnt_q <= 16'(MUTE_CYCLES);
			end else if (mute_cnt_q != 16'h0) begin
				mute_cnt_q <= mute_cnt_q - 16'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwm_muted <= 1'b0;
			pwm_out   <= 1'b0;
		end else begin
			pwm_muted <= mute_cnt_q != 16'h0;
			pwm_out   <= pwm_s && mute_cnt_q == 16'h0;
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	logic rst_seen_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_seen_q <= 1'b0;
		end else begin
			rst_seen_q <= 1'b1;
		end
	end

	prot_reset_val_a: assert property (!rst_seen_q |-> prot_q == `GPC_PROT_RST)
		else $error("first word reset value wrong");
	toff_reset_val_a: assert property (!rst_seen_q |-> toff_q == `GPC_TURNOFF_RST)
		else $error("second word reset value wrong");
	prot_write_a: assert property (
		cfg_wr_en && cfg_sel == `GPC_SEL_PROT
		|=> ##1 prot_cfg == gpc_pkg::gpc_prot_t'($past(cfg_wdata[11:0], 2)))
		else $error("first word write not seen on fields");
	toff_readback_a: assert property (
		cfg_wr_en && cfg_sel == `GPC_SEL_TURNOFF
		##1 cfg_rd_en && cfg_sel == `GPC_SEL_TURNOFF && !cfg_wr_en
		|=> cfg_rdata == $past(cfg_wdata, 2))
		else $error("second word read back differs");
	prot_upper_zero_a: assert property (
		cfg_rd_en && cfg_sel == `GPC_SEL_PROT |=> cfg_rdata[15:12] == 4'h0)
		else $error("unused first word bits not zero");
	blank_code_a: assert property (
		pc.gate_monitor_blank_time == 2'h3 && $stable(prot_q) |=> gm_blank_cycles == 6'd40)
		else $error("gate monitor blanking wrong");
	blank_code0_a: assert property (
		pc.gate_monitor_blank_time == 2'h0 |=> gm_blank_cycles == 6'd5)
		else $error("gate monitor shortest blanking wrong");
	blank_code2_a: assert property (
		pc.gate_monitor_blank_time == 2'h2 |=> gm_blank_cycles == 6'd25)
		else $error("gate monitor third blanking wrong");
	gm_mask_busy_a: assert property (
		tc.gate_monitor_mask_in_turnoff && busy_s |=> !gm_detect_allow)
		else $error("gate monitor not masked in turnoff");
	gm_off_a: assert property (pc.gate_monitor_off |=> !gm_detect_allow)
		else $error("gate monitor not off");
	gm_allow_on_a: assert property (
		!pc.gate_monitor_off && !busy_s |=> gm_detect_allow)
		else $error("gate monitor blocked while enabled");
	thr_linear_a: assert property (
		$stable(toff_q) |=> sat_threshold_mv
		== 14'd2500 + 14'd500 * 14'($past(tc.saturation_threshold_code)))
		else $error("desat threshold not linear");
	pol_off_a: assert property (
		tc.fault_turnoff_policy[1:0] == 2'h0 |=> !soft_turnoff && !two_level_turnoff)
		else $error("disabled policy raised a request");
	pol_soft_sc_a: assert property (
		flt_en.short_circuit && tc.fault_turnoff_policy == 3'h1
		|=> soft_turnoff && !two_level_turnoff)
		else $error("sc fault not soft turned off by code 1");
	pol_oc_a: assert property (
		flt_en.overcurrent && tc.fault_turnoff_policy == 3'h6 |=> two_level_turnoff)
		else $error("oc fault not covered by code 6");
	pol_tsd_a: assert property (
		flt_en.switch_thermal && tc.fault_turnoff_policy == 3'h7
		|=> two_level_turnoff && !soft_turnoff)
		else $error("thermal fault not covered by code 7");
	pol_tsd_skip_a: assert property (
		flt_en == gpc_pkg::gpc_fault_t'(4'h1) && tc.fault_turnoff_policy[1:0] == 2'h2
		|=> !soft_turnoff && !two_level_turnoff)
		else $error("thermal fault acted under code 2");
	sc_off_a: assert property (
		pc.short_protect_off && !flt_s.desat && !flt_en.overcurrent
		&& !flt_en.switch_thermal |=> !soft_turnoff && !two_level_turnoff)
		else $error("disabled short protection acted");
	mute_len_a: assert property (
		mute_flt && !mute_flt_q && tc.pwm_mute_on |=> ##1 pwm_muted && !pwm_out)
		else $error("pwm not muted after fault");
	mute_count_a: assert property (
		mute_cnt_q != 16'h0 && !(mute_flt && !mute_flt_q && tc.pwm_mute_on)
		|=> mute_cnt_q == $past(mute_cnt_q) - 16'h1)
		else $error("mute interval not counting down");
	no_mute_a: assert property (
		!tc.pwm_mute_on && mute_cnt_q == 16'h0 |=> !pwm_muted)
		else $error("pwm muted with muting off");
	pwm_pass_a: assert property (
		mute_cnt_q == 16'h0 |=> pwm_out == $past(pwm_s))
		else $error("pwm not passed while unmuted");

	// ==========================================================
	// field placement on the configuration outputs
	ovlo_off_map_a: assert property (
		prot_cfg.sec_supply_overvolt_off == $past(prot_q[`GPC_B_OVLO_OFF]))
		else $error("overvoltage lockout field misplaced");
	clamp_src_map_a: assert property (
		prot_cfg.clamp_source_select == $past(prot_q[`GPC_B_CLP_SRC]))
		else $error("clamp source field misplaced");
	clamp_off_map_a: assert property (
		prot_cfg.clamp_off == $past(prot_q[`GPC_B_CLP_OFF]))
		else $error("clamp disable field misplaced");
	oc_off_map_a: assert property (
		prot_cfg.overcurrent_protect_off == $past(prot_q[`GPC_B_OC_OFF]))
		else $error("overcurrent disable field misplaced");
	tsd_on_map_a: assert property (
		prot_cfg.switch_thermal_protect_on == $past(prot_q[`GPC_B_TSD_ON]))
		else $error("thermal enable field misplaced");
	neg_lock_map_a: assert property (
		prot_cfg.neg_supply_lockout_on == $past(prot_q[`GPC_B_NEG_LOCK]))
		else $error("negative supply lockout field misplaced");
	vce_desat_map_a: assert property (
		prot_cfg.collector_clamp_on == $past(prot_q[`GPC_B_VCE_CLP])
		&& prot_cfg.saturation_detect_on == $past(prot_q[`GPC_B_DESAT_ON]))
		else $error("clamp or desat enable field misplaced");
	chg_cur_map_a: assert property (
		turnoff_cfg.blank_cap_charge_current == $past(toff_q[`GPC_B_CHG_HI:`GPC_B_CHG_LO]))
		else $error("charge current field misplaced");
	pulldown_map_a: assert property (
		turnoff_cfg.sense_pulldown_on == $past(toff_q[`GPC_B_PULLDN]))
		else $error("pull-down enable field misplaced");
	clamp_th_map_a: assert property (
		turnoff_cfg.clamp_threshold_code == $past(toff_q[`GPC_B_CTH_HI:`GPC_B_CTH_LO]))
		else $error("clamp threshold field misplaced");
	sto_cur_map_a: assert property (
		turnoff_cfg.soft_off_current_code == $past(toff_q[`GPC_B_STO_HI:`GPC_B_STO_LO]))
		else $error("soft turn-off current field misplaced");

endmodule // gpc_prot_cfg

// ==== hw/gpc_consts.svh ====
// constants for the gate driver protection configuration bank
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

// ==========================================================
// word select and widths
`define GPC_SEL_PROT      1'h0
`define GPC_SEL_TURNOFF   1'h1
`define GPC_PROT_W        12
`define GPC_WORD_W        16

// ==========================================================
// reset values
`define GPC_PROT_RST      12'h934
`define GPC_TURNOFF_RST   16'h7741

// ==========================================================
// protection_enable_config field positions
`define GPC_B_OVLO_OFF    11
`define GPC_B_CLP_SRC     10
`define GPC_B_GATE_MONITOR_BLANK_TIME_HI   9
`define GPC_B_GATE_MONITOR_BLANK_TIME_LO   8
`define GPC_B_GM_OFF      7
`define GPC_B_CLP_OFF     6
`define GPC_B_VCE_CLP     5
`define GPC_B_DESAT_ON    4
`define GPC_B_SC_OFF      3
`define GPC_B_OC_OFF      2
`define GPC_B_TSD_ON      1
`define GPC_B_NEG_LOCK    0

// ==========================================================
// turnoff_threshold_config field positions
`define GPC_B_GM_MASK     15
`define GPC_B_DTH_HI      14
`define GPC_B_DTH_LO      11
`define GPC_B_CHG_HI      10
`define GPC_B_CHG_LO      9
`define GPC_B_PULLDN      8
`define GPC_B_CTH_HI      7
`define GPC_B_CTH_LO      6
`define GPC_B_STO_HI      5
`define GPC_B_STO_LO      4
`define GPC_B_POL_HI      3
`define GPC_B_POL_LO      1
`define GPC_B_MUTE        0

// ==========================================================
// timing
`define GPC_CLK_NS        100
`define GPC_GM_BLK0_NS    500
`define GPC_GM_BLK1_NS    1000
`define GPC_GM_BLK2_NS    2500
`define GPC_GM_BLK3_NS    4000
`define GPC_DTH_BASE_MV   2500
`define GPC_DTH_STEP_MV   500
`define GPC_MUTE_CYCLES   16

`endif

// ==== hw/gpc_pkg.sv ====
// types of the gate driver protection configuration bank
package gpc_pkg;

	// protection_enable_config, bits 11..0
	typedef struct packed {
		logic       sec_supply_overvolt_off;
		logic       clamp_source_select;
		logic [1:0] gate_monitor_blank_time;
		logic       gate_monitor_off;
		logic       clamp_off;
		logic       collector_clamp_on;
		logic       saturation_detect_on;
		logic       short_protect_off;
		logic       overcurrent_protect_off;
		logic       switch_thermal_protect_on;
		logic       neg_supply_lockout_on;
	} gpc_prot_t;

	// turnoff_threshold_config, bits 15..0
	typedef struct packed {
		logic       gate_monitor_mask_in_turnoff;
		logic [3:0] saturation_threshold_code;
		logic [1:0] blank_cap_charge_current;
		logic       sense_pulldown_on;
		logic [1:0] clamp_threshold_code;
		logic [1:0] soft_off_current_code;
		logic [2:0] fault_turnoff_policy;
		logic       pwm_mute_on;
	} gpc_turnoff_t;

	// fault inputs from the analog comparators
	typedef struct packed {
		logic short_circuit;
		logic desat;
		logic overcurrent;
		logic switch_thermal;
	} gpc_fault_t;

endpackage

// ==== dv/gpc_prot_cfg_tb.sv ====
// self-checking testbench for the protection configuration bank
`timescale 1ns/1ps

module testbench;
	localparam int          MUTE = 4;
	localparam logic [15:0] PAT [4] = '{16'ha5a5, 16'h5a5a, 16'hffff, 16'h0000};
	localparam logic [15:0] BLK [4] = '{16'h0005, 16'h000a, 16'h0019, 16'h0028};

	logic                  core_clk;
	logic                  rst_b;
	logic                  cfg_wr_en;
	logic                  cfg_sel;
	logic [15:0]           cfg_wdata;
	logic                  cfg_rd_en;
	logic [15:0]           cfg_rdata;
	gpc_pkg::gpc_fault_t   fault_in;
	logic                  turnoff_busy_in;
	logic                  pwm_in;
	gpc_pkg::gpc_prot_t    prot_cfg;
	gpc_pkg::gpc_turnoff_t turnoff_cfg;
	logic                  soft_turnoff;
	logic                  two_level_turnoff;
	logic                  gm_detect_allow;
	logic [5:0]            gm_blank_cycles;
	logic [13:0]           sat_threshold_mv;
	logic                  pwm_muted;
	logic                  pwm_out;
	int                    err_total;
	int                    checks_done;

	gpc_prot_cfg #(.MUTE_CYCLES(MUTE)) i_gpc_prot_cfg (
		.core_clk          (core_clk),
		.rst_b             (rst_b),
		.cfg_wr_en         (cfg_wr_en),
		.cfg_sel           (cfg_sel),
		.cfg_wdata         (cfg_wdata),
		.cfg_rd_en         (cfg_rd_en),
		.cfg_rdata         (cfg_rdata),
		.fault_in          (fault_in),
		.turnoff_busy_in   (turnoff_busy_in),
		.pwm_in            (pwm_in),
		.prot_cfg          (prot_cfg),
		.turnoff_cfg       (turnoff_cfg),
		.soft_turnoff      (soft_turnoff),
		.two_level_turnoff (two_level_turnoff),
		.gm_detect_allow   (gm_detect_allow),
		.gm_blank_cycles   (gm_blank_cycles),
		.sat_threshold_mv  (sat_threshold_mv),
		.pwm_muted         (pwm_muted),
		.pwm_out           (pwm_out)
	);

	// ==========================================================
	// clock and watchdog
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		#500000;
		err_total++;
		print_verdict();
	end

	// ==========================================================
	// access tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic do_reset();
		rst_b = 1'h0;
		cyc(3);
		rst_b = 1'h1;
	endtask

	// write lands on next edge, outputs follow one edge later
	task automatic wr(input logic sel, input logic [15:0] d);
		cfg_wr_en = 1'h1;
		cfg_sel = sel;
		cfg_wdata = d;
		cyc(1);
		cfg_wr_en = 1'h0;
		cyc(2);
	endtask

	task automatic rd(input logic sel, input logic [15:0] exp);
		cfg_rd_en = 1'h1;
		cfg_sel = sel;
		cyc(1);
		cfg_rd_en = 1'h0;
		check(cfg_rdata, exp);
		cyc(1);
	endtask

	// one fault kind under one policy code, turn-off requests compared
	task automatic fault_case(input int f, input logic [2:0] pol, input logic en);
		logic cov;
		cov = en && (f < 2 ? pol[1:0] != 2'h0 : f == 2 ? pol[1:0] >= 2'h2 : pol[1:0] == 2'h3);
		wr(1'h1, {12'h774, pol, 1'h0});
		fault_in = gpc_pkg::gpc_fault_t'(4'h8 >> f);
		cyc(4);
		check({15'h0, soft_turnoff}, {15'h0, cov && !pol[2]});
		check({15'h0, two_level_turnoff}, {15'h0, cov && pol[2]});
		fault_in = '0;
		cyc(4);
	endtask

	task automatic print_verdict();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		cfg_wr_en = 1'h0;
		cfg_sel = 1'h0;
		cfg_wdata = '0;
		cfg_rd_en = 1'h0;
		fault_in = '0;
		turnoff_busy_in = 1'h0;
		pwm_in = 1'h1;
		err_total = 0;
		checks_done = 0;
		do_reset();
		rd(1'h0, 16'h0934);
		rd(1'h1, 16'h7741);
		check({4'h0, prot_cfg}, 16'h0934);
		check(turnoff_cfg, 16'h7741);
		check({10'h0, gm_blank_cycles}, 16'h000a);
		check({2'h0, sat_threshold_mv}, 16'(9500));
		for (int i = 0; i < 4; i++) begin
			wr(1'h0, PAT[i]);
			rd(1'h0, PAT[i] & 16'h0fff);
			check({4'h0, prot_cfg}, PAT[i] & 16'h0fff);
			wr(1'h1, PAT[i]);
			rd(1'h1, PAT[i]);
			check(turnoff_cfg, PAT[i]);
		end
		// back-to-back write then read of the second word
		cfg_wr_en = 1'h1;
		cfg_sel = 1'h1;
		cfg_wdata = 16'h3c96;
		cyc(1);
		cfg_wr_en = 1'h0;
		cfg_rd_en = 1'h1;
		cyc(1);
		cfg_rd_en = 1'h0;
		check(cfg_rdata, 16'h3c96);
		cyc(1);
		for (int c = 0; c < 4; c++) begin
			wr(1'h0, 16'(c << 8));
			check({10'h0, gm_blank_cycles}, BLK[c]);
			check({15'h0, gm_detect_allow}, 16'h0001);
		end
		for (int c = 0; c < 16; c++) begin
			wr(1'h1, 16'(c << 11));
			check({2'h0, sat_threshold_mv}, 16'(2500 + 500 * c));
		end
		wr(1'h0, 16'h0080);
		check({15'h0, gm_detect_allow}, 16'h0000);
		wr(1'h0, 16'h0012);
		for (int p = 0; p < 8; p++)
			for (int f = 0; f < 4; f++)
				fault_case(f, 3'(p), 1'h1);
		// short, desat, overcurrent and thermal protections off: no request for any fault
		wr(1'h0, 16'h000c);
		for (int f = 0; f < 4; f++)
			fault_case(f, 3'h3, 1'h0);
		wr(1'h0, 16'h0012);
		wr(1'h1, 16'h7741);
		fault_in.short_circuit = 1'h1;
		cyc(4);
		check({14'h0, pwm_muted, pwm_out}, 16'h0002);
		cyc(MUTE + 4);
		check({14'h0, pwm_muted, pwm_out}, 16'h0001);
		fault_in = '0;
		wr(1'h1, 16'h7740);
		fault_in.overcurrent = 1'h1;
		cyc(4);
		check({14'h0, pwm_muted, pwm_out}, 16'h0001);
		fault_in = '0;
		pwm_in = 1'h0;
		cyc(4);
		check({15'h0, pwm_out}, 16'h0000);
		pwm_in = 1'h1;
		wr(1'h1, 16'hf741);
		turnoff_busy_in = 1'h1;
		cyc(4);
		check({15'h0, gm_detect_allow}, 16'h0000);
		wr(1'h1, 16'h7741);
		check({15'h0, gm_detect_allow}, 16'h0001);
		turnoff_busy_in = 1'h0;
		do_reset();
		rd(1'h0, 16'h0934);
		rd(1'h1, 16'h7741);
		print_verdict();
	end
endmodule // testbench
